// ===== ars_pkg.sv
// Constants and carrier types for the converter input/reference sequencer
package ars_pkg;

    localparam logic [1:0] ARS_REF_EXT = 2'h0;
    localparam logic [1:0] ARS_REF_VDD = 2'h1;
    localparam logic [1:0] ARS_REF_SENSOR = 2'h2;
    localparam logic [1:0] ARS_REF_VDD_ALT = 2'h3;

    localparam logic [2:0] ARS_INS_EXT = 3'h0;
    localparam logic [2:0] ARS_INS_BANDGAP = 3'h1;
    localparam logic [2:0] ARS_INS_SENSOR = 3'h2;
    localparam logic [2:0] ARS_INS_GND_A = 3'h3;
    localparam logic [2:0] ARS_INS_GND_B = 3'h4;
    localparam logic [2:0] ARS_INS_FORBIDDEN = 3'h7;

    localparam logic [1:0] ARS_MODE_FAST = 2'h0;
    localparam logic [1:0] ARS_MODE_LOW_CURRENT = 2'h3;

    localparam int ARS_NUM_PINS = 8;

    // Sampling / conversion lengths in converter clock periods
    localparam logic [5:0] ARS_SMP_12 = 6'h04;
    localparam logic [5:0] ARS_SMP_12_SENSOR = 6'h2E;
    localparam logic [5:0] ARS_SMP_10_LOW = 6'h02;
    localparam logic [5:0] ARS_SMP_10 = 6'h03;
    localparam logic [5:0] ARS_CNV_12 = 6'h0C;
    localparam logic [5:0] ARS_CNV_10 = 6'h0A;

    localparam logic [11:0] ARS_FULL_12 = 12'hFFF;
    localparam logic [11:0] ARS_FULL_10 = 12'h3FF;

    localparam logic [2:0] ARS_DIV_RESET = 3'h0;
    localparam logic [2:0] ARS_INS_RESET = 3'h0;

    typedef enum logic [1:0] {
        ARS_SRC_NONE,
        ARS_SRC_PIN,
        ARS_SRC_BANDGAP,
        ARS_SRC_SENSOR
    } ars_src_kind_t;

    typedef struct packed {
        logic ref_ext;
        logic ref_vdd;
        logic ref_sensor;
    } ars_ref_route_t;

    typedef struct packed {
        logic [ARS_NUM_PINS-1:0] pin_connect;
        logic bandgap;
        logic sensor;
        logic ground;
    } ars_in_route_t;

    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } ars_result_t;

endpackage

// ===== ars_sequencer.sv
// Converter reference/input routing and conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module ars_sequencer
    import ars_pkg::*;
#(
    parameter int NUM_PINS = ARS_NUM_PINS
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic converter_power_enable,
    input wire logic start_bit,
    input wire logic result_format_select,
    input wire logic resolution_select,
    input wire logic [1:0] conversion_mode_select,
    input wire logic [1:0] reference_source_select,
    input wire logic temp_sensor_enable,
    input wire logic [2:0] converter_clock_divider,
    input wire logic [3:0] external_channel_select,
    input wire logic [2:0] internal_input_select,
    input wire logic internal_input_write,
    input wire logic [NUM_PINS-1:0] pin_function_select,
    input wire logic global_interrupt_enable,
    input wire logic converter_interrupt_enable,
    input wire logic converter_interrupt_flag_clear,
    input wire logic comparator_out,
    output logic conversion_busy_flag,
    output logic converter_interrupt_flag,
    output logic converter_irq,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte,
    output logic analog_power_on,
    output logic analog_sample,
    output logic [11:0] sar_trial,
    output logic [2:0] internal_input_state,
    output ars_ref_route_t ref_route,
    output ars_in_route_t in_route,
    output logic [NUM_PINS-1:0] pin_digital_disable,
    output logic [NUM_PINS-1:0] pin_pullhigh_disable,
    output logic [NUM_PINS-1:0] pin_direction_override
);

    ////////////////////////////////////////////////////////////////////////
    // Converter clock enable: core_clk divided by 2^divider

    logic [6:0] div_cnt;
    logic adck_en;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt <= 7'h00;
            adck_en <= 1'b0;
        end
        else
        begin
            if (div_cnt >= ((7'h01 << converter_clock_divider) - 7'h01))
            begin
                div_cnt <= 7'h00;
                adck_en <= 1'b1;
            end
            else
            begin
                div_cnt <= div_cnt + 7'h01;
                adck_en <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal input selector register

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            internal_input_state <= ARS_INS_RESET;
        else if (internal_input_write &&
                 internal_input_select != ARS_INS_FORBIDDEN)
            internal_input_state <= internal_input_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog routing, registered so outputs come from flops

    function automatic logic ins_is_external(input logic [2:0] code);
        return code == ARS_INS_EXT || code == 3'h5 || code == 3'h6;
    endfunction

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_route <= '0;
            in_route <= '0;
        end
        else
        begin
            // Everything open while powered down
            ref_route.ref_ext <= converter_power_enable &&
                reference_source_select == ARS_REF_EXT;
            ref_route.ref_vdd <= converter_power_enable &&
                (reference_source_select == ARS_REF_VDD ||
                 reference_source_select == ARS_REF_VDD_ALT);
            ref_route.ref_sensor <= converter_power_enable &&
                reference_source_select == ARS_REF_SENSOR;
            in_route.pin_connect <= '0;
            if (converter_power_enable &&
                ins_is_external(internal_input_state) &&
                !external_channel_select[3])
                in_route.pin_connect[external_channel_select[2:0]] <= 1'b1;
            in_route.bandgap <= converter_power_enable &&
                internal_input_state == ARS_INS_BANDGAP;
            in_route.sensor <= converter_power_enable &&
                internal_input_state == ARS_INS_SENSOR;
            in_route.ground <= converter_power_enable &&
                (internal_input_state == ARS_INS_GND_A ||
                 internal_input_state == ARS_INS_GND_B);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_digital_disable <= '0;
            pin_pullhigh_disable <= '0;
            pin_direction_override <= '0;
        end
        else
        begin
            pin_digital_disable <= pin_function_select;
            pin_pullhigh_disable <= pin_function_select;
            pin_direction_override <= pin_function_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start pulse: armed on rising edge, fires on following falling edge

    logic start_d;
    logic start_armed;
    logic start_go;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            start_d <= 1'b0;
            start_armed <= 1'b0;
        end
        else
        begin
            start_d <= start_bit;
            if (start_bit && !start_d)
                start_armed <= 1'b1;
            else if (start_go)
                start_armed <= 1'b0;
        end
    end

    assign start_go = start_armed && !start_bit && start_d &&
        converter_power_enable;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    typedef enum logic [1:0] {
        ARS_IDLE,
        ARS_SAMPLE,
        ARS_CONVERT
    } ars_state_t;

    ars_state_t state;
    logic [5:0] phase_cnt;
    logic [3:0] bit_idx;
    logic res10;
    logic [5:0] next_smp_len;
    logic done;

    always_comb
    begin
        if (resolution_select)
            next_smp_len = (conversion_mode_select == ARS_MODE_LOW_CURRENT)
                ? ARS_SMP_10_LOW : ARS_SMP_10;
        else if (internal_input_state == ARS_INS_SENSOR)
            next_smp_len = ARS_SMP_12_SENSOR;
        else
            next_smp_len = ARS_SMP_12;
    end

    assign done = state == ARS_CONVERT && adck_en && phase_cnt == 6'h01;

    // Hardware-only sequencing; no processor stall
    // sar_trial is the working word itself (decided bits plus the bit
    // under test), so the comparator never sees a stale trial
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ARS_IDLE;
            phase_cnt <= 6'h00;
            bit_idx <= 4'h0;
            res10 <= 1'b0;
            sar_trial <= 12'h000;
        end
        else if (!converter_power_enable)
        begin
            state <= ARS_IDLE;
            phase_cnt <= 6'h00;
            sar_trial <= 12'h000;
        end
        else
        begin
            case (state)
                ARS_IDLE:
                    if (start_go)
                    begin
                        state <= ARS_SAMPLE;
                        phase_cnt <= next_smp_len;
                        res10 <= resolution_select;
                        sar_trial <= 12'h000;
                    end
                ARS_SAMPLE:
                    if (adck_en)
                    begin
                        if (phase_cnt == 6'h01)
                        begin
                            state <= ARS_CONVERT;
                            phase_cnt <= res10 ? ARS_CNV_10 : ARS_CNV_12;
                            bit_idx <= res10 ? 4'h9 : 4'hB;
                            // First trial: top bit of the active resolution
                            sar_trial <= res10 ? 12'h200 : 12'h800;
                        end
                        else
                            phase_cnt <= phase_cnt - 6'h01;
                    end
                ARS_CONVERT:
                    if (adck_en)
                    begin
                        // One bit decided per converter clock, MSB first
                        if (phase_cnt == 6'h01)
                        begin
                            state <= ARS_IDLE;
                            sar_trial <= 12'h000;
                        end
                        else
                        begin
                            sar_trial[bit_idx] <= comparator_out;
                            sar_trial[bit_idx - 4'h1] <= 1'b1;
                            bit_idx <= bit_idx - 4'h1;
                            phase_cnt <= phase_cnt - 6'h01;
                        end
                    end
                default:
                    state <= ARS_IDLE;
            endcase
        end
    end

    // Sampling and power indicators for the analog side
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            analog_sample <= 1'b0;
            analog_power_on <= 1'b0;
        end
        else
        begin
            analog_sample <= state == ARS_SAMPLE;
            analog_power_on <= converter_power_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy, results, completion flag

    logic [11:0] final_code;

    always_comb
    begin
        final_code = sar_trial;
        final_code[bit_idx] = comparator_out;
        // Mask to the bit width of the active resolution
        final_code = final_code & (res10 ? ARS_FULL_10 : ARS_FULL_12);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            conversion_busy_flag <= 1'b0;
        else if (start_go && state == ARS_IDLE)
            conversion_busy_flag <= 1'b1;
        else if (done || !converter_power_enable)
            conversion_busy_flag <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end
        else if (done)
        begin
            if (result_format_select)
            begin
                // Right aligned
                result_high_byte <= {4'h0, final_code[11:8]};
                result_low_byte <= final_code[7:0];
            end
            else if (res10)
            begin
                // Left aligned 10-bit
                result_high_byte <= final_code[9:2];
                result_low_byte <= {final_code[1:0], 6'h00};
            end
            else
            begin
                result_high_byte <= final_code[11:4];
                result_low_byte <= {final_code[3:0], 4'h0};
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            converter_interrupt_flag <= 1'b0;
        else if (done)
            converter_interrupt_flag <= 1'b1;
        else if (converter_interrupt_flag_clear)
            converter_interrupt_flag <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            converter_irq <= 1'b0;
        else
            converter_irq <= done && global_interrupt_enable &&
                converter_interrupt_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_forbidden_refused: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (internal_input_write && internal_input_select == ARS_INS_FORBIDDEN)
        |=> $stable(internal_input_state))
        else $error("Forbidden input code was taken");

    a_busy_on_start: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (start_go && state == ARS_IDLE) |=> conversion_busy_flag)
        else $error("Busy did not rise on start");

    a_result_held: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !done |=> $stable(result_high_byte) && $stable(result_low_byte))
        else $error("Result changed without completion");

    a_flag_on_done: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        done |=> converter_interrupt_flag && !conversion_busy_flag)
        else $error("Completion did not set flag and drop busy");

    a_sample_to_conv: assert property (@(posedge core_clk)
        disable iff (!arst_n || !converter_power_enable)
        (state == ARS_SAMPLE && adck_en && phase_cnt == 6'h01)
        |=> state == ARS_CONVERT &&
            phase_cnt == (res10 ? ARS_CNV_10 : ARS_CNV_12))
        else $error("Conversion length wrong");

    a_smp_10_low: assert property (@(posedge core_clk)
        disable iff (!arst_n || !converter_power_enable)
        (state == ARS_IDLE && start_go && resolution_select &&
         conversion_mode_select == ARS_MODE_LOW_CURRENT)
        |=> phase_cnt == 6'h02)
        else $error("Low current sample length wrong");

    a_smp_sensor: assert property (@(posedge core_clk)
        disable iff (!arst_n || !converter_power_enable)
        (state == ARS_IDLE && start_go && !resolution_select &&
         internal_input_state == ARS_INS_SENSOR)
        |=> phase_cnt == 6'h2E)
        else $error("Sensor sample length wrong");

    a_ref_exclusive: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $onehot0(ref_route))
        else $error("Two references routed at once");

    a_power_off_idle: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !converter_power_enable |=> state == ARS_IDLE &&
            !conversion_busy_flag)
        else $error("Converter active while powered off");

endmodule

`default_nettype wire

// ===== ars_front_model.sv
// Analog front end model: comparator answering the trial word
`timescale 1ns/1ps
`default_nettype none

module ars_front_model
    import ars_pkg::*;
(
    input wire logic core_clk,
    input wire logic analog_power_on,
    input wire logic [11:0] sar_trial,
    input wire logic [11:0] vin_code,
    output logic comparator_out
);
    logic junk = 1'b0;

    // Unpowered comparator output is meaningless, so it wanders
    always_ff @(posedge core_clk)
        junk <= ~junk;

    assign comparator_out = analog_power_on ? (vin_code >= sar_trial) : junk;
endmodule

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the converter input/reference sequencer
`timescale 1ns/1ps
`default_nettype none

module tb
    import ars_pkg::*;
;
    logic core_clk, arst_n, converter_power_enable, start_bit;
    logic result_format_select, resolution_select, temp_sensor_enable;
    logic internal_input_write, global_interrupt_enable;
    logic converter_interrupt_enable, converter_interrupt_flag_clear;
    logic comparator_out, conversion_busy_flag, converter_interrupt_flag;
    logic converter_irq, analog_power_on, analog_sample;
    logic [1:0] conversion_mode_select, reference_source_select;
    logic [2:0] converter_clock_divider, internal_input_select;
    logic [2:0] internal_input_state;
    logic [3:0] external_channel_select;
    logic [7:0] pin_function_select, pin_digital_disable;
    logic [7:0] pin_pullhigh_disable, pin_direction_override;
    logic [7:0] result_high_byte, result_low_byte;
    logic [11:0] sar_trial, vin_code;
    ars_ref_route_t ref_route;
    ars_in_route_t in_route;
    int err_total, checks, st, k, h, s, r;

    ars_sequencer dut
    (
        .core_clk, .arst_n, .converter_power_enable, .start_bit,
        .result_format_select, .resolution_select, .conversion_mode_select,
        .reference_source_select, .temp_sensor_enable,
        .converter_clock_divider, .external_channel_select,
        .internal_input_select, .internal_input_write, .pin_function_select,
        .global_interrupt_enable, .converter_interrupt_enable,
        .converter_interrupt_flag_clear, .comparator_out,
        .conversion_busy_flag, .converter_interrupt_flag, .converter_irq,
        .result_high_byte, .result_low_byte, .analog_power_on,
        .analog_sample, .sar_trial, .internal_input_state, .ref_route,
        .in_route, .pin_digital_disable, .pin_pullhigh_disable,
        .pin_direction_override
    );

    ars_front_model front
    (
        .core_clk, .analog_power_on, .sar_trial, .vin_code, .comparator_out
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Inputs always move just after the rising edge
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [15:0] fmt_exp(int code, bit r10, bit right);
        if (right)
            return 16'(code);
        return 16'(code << (r10 ? 6 : 4));
    endfunction

    function automatic logic [10:0] in_exp(int c, int ch);
        logic [7:0] p;
        p = (c == 0 || c == 5 || c == 6) && ch < 8 ? 8'h01 << ch : 8'h00;
        return {p, c == 1, c == 2, c == 3 || c == 4};
    endfunction

    task automatic pulse_start();
        start_bit = 1'b1;
        tick(1);
        start_bit = 1'b0;
        tick(1);
    endtask

    task automatic select_input(input int c);
        internal_input_select = 3'(c);
        internal_input_write = 1'b1;
        tick(1);
        internal_input_write = 1'b0;
        tick(2);
        if (c != 7)
            st = c;
        check("in_state", internal_input_state, st);
        check("in_route", in_route, in_exp(st, 8));
    endtask

    task automatic convert(input bit r10, input int m, input int sl,
        input logic [11:0] code, input bit right, input bit en,
        input int d, input bit again);
        int cyc, sc, ic, lo;
        logic [15:0] old;
        bit held, ok;
        resolution_select = r10;
        conversion_mode_select = 2'(m);
        result_format_select = right;
        converter_clock_divider = 3'(d);
        vin_code = code;
        global_interrupt_enable = en;
        converter_interrupt_enable = en;
        old = {result_high_byte, result_low_byte};
        held = 1'b1;
        pulse_start();
        check("busy_rise", conversion_busy_flag, 1);
        cyc = 1;
        sc = 0;
        while (conversion_busy_flag === 1'b1 && cyc < 3000)
        begin
            held &= ({result_high_byte, result_low_byte} === old);
            sc += analog_sample;
            // A second pulse in mid-conversion must be ignored
            start_bit = again && cyc == 5;
            tick(1);
            cyc++;
        end
        // First enable may fall anywhere in the first divider period
        lo = (sl + (r10 ? 10 : 12)) << d;
        ok = cyc >= lo - (1 << d) + 2 && cyc <= lo + 1;
        check("busy_len", ok, 1);
        if (d == 0)
        begin
            ok = sc >= sl && sc <= sl + 1;
            check("smp_len", ok, 1);
        end
        check("held", held, 1);
        old = fmt_exp(code, r10, right);
        check("result", {result_high_byte, result_low_byte}, old);
        check("flag_set", converter_interrupt_flag, 1);
        ic = 0;
        repeat (3)
        begin
            ic += converter_irq;
            tick(1);
        end
        check("irq", ic, en);
        check("idle", conversion_busy_flag, 0);
        check("flag_hold", converter_interrupt_flag, 1);
        converter_interrupt_flag_clear = 1'b1;
        tick(1);
        converter_interrupt_flag_clear = 1'b0;
        tick(1);
        check("flag_clr", converter_interrupt_flag, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Whole run is under a thousand cycles; the 20000-cycle limit is ample margin
    initial
    begin
        #400000;
        err_total++;
        results();
    end

    initial
    begin
        {arst_n, converter_power_enable, start_bit, result_format_select,
            resolution_select, temp_sensor_enable, internal_input_write,
            global_interrupt_enable, converter_interrupt_enable,
            converter_interrupt_flag_clear, conversion_mode_select,
            reference_source_select, converter_clock_divider,
            internal_input_select, pin_function_select, vin_code} = '0;
        external_channel_select = 4'h8;
        err_total = 0;
        checks = 0;
        st = 0;
        r = $urandom(32'hE5FBDDDB);
        repeat (4) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        check("rst_out", {conversion_busy_flag, converter_interrupt_flag,
            converter_irq, analog_power_on, result_high_byte,
            result_low_byte}, 0);
        repeat (4)
        begin
            s = $urandom_range(255);
            pin_function_select = 8'(s);
            tick(2);
            check("dig", pin_digital_disable, s);
            check("pull", pin_pullhigh_disable, s);
            check("dir", pin_direction_override, s);
        end
        temp_sensor_enable = 1'b1;
        converter_power_enable = 1'b1;
        tick(2);
        check("power", analog_power_on, 1);
        for (k = 0; k < 4; k++)
        begin
            // Reference pin function never driven as an input here
            reference_source_select = 2'(k);
            tick(2);
            s = k == 0 ? 4 : (k == 2 ? 1 : 2);
            check("ref", ref_route, s);
        end
        for (k = 0; k < 24; k++)
        begin
            h = k % 8;
            external_channel_select = 4'h8 | 4'($urandom_range(7));
            tick(1);
            select_input(h);
            if (h == 0 || h == 5 || h == 6)
            begin
                s = $urandom_range(15);
                external_channel_select = 4'(s);
                tick(2);
                check("pin", in_route, in_exp(h, s));
            end
        end
        select_input(0);
        external_channel_select = 4'h0;
        tick(1);
        convert(0, 0, 4, 12'($urandom), 1, 1, 0, 0);
        convert(0, 1, 4, 12'hFFF, 0, 0, 0, 1);
        convert(1, 3, 2, 12'h3FF, 1, 1, 0, 0);
        convert(1, 3, 2, 12'h3FF, 0, 0, 0, 0);
        for (k = 0; k < 3; k++)
        begin
            s = $urandom_range(1023);
            convert(1, k, 3, 12'(s), k[0], 1, 0, 0);
        end
        for (k = 0; k < 6; k++)
        begin
            r = $urandom_range(1);
            h = $urandom_range(3);
            s = r ? (h == 3 ? 2 : 3) : 4;
            convert(r, h, s, 12'($urandom_range(r ? 1023 : 4095)),
                $urandom_range(1), $urandom_range(1), $urandom_range(2), 0);
        end
        external_channel_select = 4'hF;
        tick(1);
        select_input(2);
        convert(0, 0, 46, 12'($urandom), 0, 1, 0, 0);
        pulse_start();
        tick(8);
        converter_power_enable = 1'b0;
        tick(2);
        check("abort_busy", conversion_busy_flag, 0);
        check("abort_pwr", analog_power_on, 0);
        check("abort_flag", converter_interrupt_flag, 0);
        check("abort_route", in_route, 0);
        results();
    end
endmodule

`default_nettype wire
